//--- gpt_pkg.sv
// ****************************************************************
// timebase package
// ****************************************************************
package gpt_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // register offsets
    localparam logic [3:0] OFF_CTRL_LO = 4'h0;
    localparam logic [3:0] OFF_CTRL_HI = 4'h1;
    localparam logic [3:0] OFF_STAT = 4'h2;
    localparam logic [3:0] OFF_TMR_LO = 4'h3;
    localparam logic [3:0] OFF_TMR_HI = 4'h4;
    localparam logic [3:0] OFF_PER_LO = 4'h5;
    localparam logic [3:0] OFF_PER_HI = 4'h6;

    // control_low_reg fields
    localparam int unsigned CL_MODE_LSB = 0;
    localparam int unsigned CL_CAPTURE_COMPARE_SELECT_BIT = 4;
    localparam int unsigned CL_CASCADE_BIT = 5;
    localparam int unsigned CL_CLOCK_SOURCE_SELECT_LSB = 8;
    // control_high_reg fields
    localparam int unsigned CH_SYNC_LSB = 0;
    localparam int unsigned CH_TRIGGER_ENABLE_BIT = 7;
    // status_low_reg fields
    localparam int unsigned ST_PRI_BIT = 0;
    localparam int unsigned ST_CMP_BIT = 1;
    localparam int unsigned ST_TRIGGER_CLEAR_BIT = 5;
    localparam int unsigned ST_TRIG_BIT = 7;

    // encodings
    localparam logic [3:0] MODE_TIMER = 4'h0;
    localparam logic [2:0] CLOCK_SOURCE_SELECT_SYS = 3'h0;
    localparam logic [4:0] SYNC_NONE = 5'h1f;

    // reset values
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [15:0] RST_TMR = 16'h0000;
    localparam logic [15:0] RST_PER = 16'hffff;
endpackage : gpt_pkg

//--- gpt_trig_if.sv
`timescale 1ns/100ps
// ****************************************************************
// sync / trigger carrier
// ****************************************************************
interface gpt_trig_if;
    logic [4:0] src_sel;
    logic trig_en;
    logic trig_clear;
    logic sync_clr;
    logic hold;
    logic trig_status;
    modport ctl (output src_sel, trig_en, trig_clear,
                 input sync_clr, hold, trig_status);
    modport src (input src_sel, trig_en, trig_clear,
                 output sync_clr, hold, trig_status);
endinterface : gpt_trig_if

//--- gpt_clkgen.sv
`timescale 1ns/100ps
// ****************************************************************
// time-base tick generator
// ****************************************************************
module gpt_clkgen
    import gpt_pkg::*;
(
    input wire logic sys_clk_i, // system clock
    input wire logic rst_i, // sync reset
    input wire logic [7:1] clk_src_i, // alternate sources
    input wire logic [2:0] clk_sel_i, // source select
    output logic tick_o // one-cycle time-base enable
);
    typedef struct packed {
        logic [7:1] prev;
    } gpt_clk_s;

    gpt_clk_s s;
    gpt_clk_s next_s;

    always_comb begin
        next_s.prev = clk_src_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // rising edge of selected source, every cycle for system clock
    always_comb begin
        if (clk_sel_i == CLOCK_SOURCE_SELECT_SYS) begin
            tick_o = 1'b1; // [R10] [R18]
        end else begin
            tick_o = clk_src_i[clk_sel_i] & ~s.prev[clk_sel_i]; // [R10]
        end
    end
endmodule : gpt_clkgen

//--- gpt_trig.sv
`timescale 1ns/100ps
// ****************************************************************
// sync / trigger source logic
// ****************************************************************
module gpt_trig
    import gpt_pkg::*;
(
    input wire logic sys_clk_i, // system clock
    input wire logic rst_i, // sync reset
    input wire logic [31:0] sync_src_i, // on-chip sync sources
    gpt_trig_if.src tif // control and results
);
    typedef struct packed {
        logic trig_status;
    } gpt_trig_s;

    gpt_trig_s s;
    gpt_trig_s next_s;
    logic sel_level;

    assign sel_level = sync_src_i[tif.src_sel]; // [R11]

    always_comb begin
        next_s = s;
        if (!tif.trig_en) begin
            next_s.trig_status = 1'b0;
        end else if (sel_level) begin
            next_s.trig_status = 1'b1; // [R14] set wins over clear
        end else if (tif.trig_clear) begin
            next_s.trig_status = 1'b0; // [R16]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // code 11111 never syncs
    assign tif.sync_clr = !tif.trig_en && (tif.src_sel != SYNC_NONE)
                          && sel_level; // [R12] [R13]
    assign tif.hold = tif.trig_en && !s.trig_status; // [R14] [R15]
    assign tif.trig_status = s.trig_status;
endmodule : gpt_trig

//--- gpt_timebase.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
// ****************************************************************
// general-purpose timebase
// ****************************************************************
// How it works
// R1: timer counts only when select bit is 0 and mode field is 0000.
// R2: cascade clear gives two 16-bit counters, set gives one 32-bit.
// R3: split primary counts low counter against low period.
// R4: split secondary counts high counter against high period.
// R5: only primary drives sync out and takes the external sync input.
// R6: secondary has no sync or trigger output, periodic event only.
// R7: split secondary period match raises the compare event flag.
// R8: in 32-bit mode low overflow increments high counter by one.
// R9: software sets cascade before loading counter or period for 32-bit.
// R10: three-bit clock select picks one of eight sources, 000 system.
// R11: five-bit source select picks the sync or trigger input.
// R12: in sync operation the selected input clears the counter.
// R13: sync applies when trigger enable is 0; code 11111 not used.
// R14: trigger operation holds counter at zero until input asserts.
// R15: counter runs while the trigger status flag stays set.
// R16: writing trigger clear drops the flag, zeroes and holds counter.
// R17: software enables trigger only with the system clock selected.
// R18: time base is derived from a clock already on the chip.
// R19: on period match the counter returns to zero with a period event.
module gpt_timebase
    import gpt_pkg::*;
(
    input wire logic sys_clk_i, // system clock
    input wire logic rst_i, // sync reset
    input wire logic [ADDR_W-1:0] addr_i, // register index
    input wire logic [DATA_W-1:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [DATA_W-1:0] rdata_o, // read data, cycle after read
    input wire logic [7:1] clk_src_i, // alternate time-base sources
    input wire logic [31:0] sync_src_i, // sync / trigger sources
    output logic sync_out_o, // primary period pulse
    output logic compare_event_o, // compare event pulse
    output logic trig_status_o // trigger status level
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [3:0] mode;
        logic capture_compare_select;
        logic cascade;
        logic [2:0] clock_source_select;
        logic [4:0] sync_sel;
        logic trig_en;
        logic [15:0] tmr_lo;
        logic [15:0] tmr_hi;
        logic [15:0] per_lo;
        logic [15:0] per_hi;
        logic pri_flag;
        logic cmp_flag;
        logic sync_out;
        logic cmp_evt;
        logic [15:0] rdata;
    } gpt_state_s;

    gpt_state_s s;
    gpt_state_s next_s;
    logic tick;
    logic timer_on;
    logic clr_any;
    logic wr_stat;
    logic wr_tmr;
    logic [31:0] tmr_32;
    logic [31:0] per_32;

    gpt_trig_if tif ();

    // ****************************************************************
    // helpers
    // ****************************************************************
    gpt_clkgen u_clkgen (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .clk_src_i(clk_src_i),
        .clk_sel_i(s.clock_source_select),
        .tick_o(tick)
    );

    gpt_trig u_trig (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .sync_src_i(sync_src_i),
        .tif(tif)
    );

    assign wr_stat = wr_i && (addr_i == OFF_STAT);
    assign wr_tmr = wr_i && ((addr_i == OFF_TMR_LO)
                             || (addr_i == OFF_TMR_HI));
    assign tif.src_sel = s.sync_sel; // [R11]
    assign tif.trig_en = s.trig_en;
    assign tif.trig_clear = wr_stat && wdata_i[ST_TRIGGER_CLEAR_BIT]; // [R16]
    assign timer_on = !s.capture_compare_select && (s.mode == MODE_TIMER); // [R1]
    assign clr_any = tif.sync_clr || tif.hold || tif.trig_clear;
    assign tmr_32 = {s.tmr_hi, s.tmr_lo};
    assign per_32 = {s.per_hi, s.per_lo};

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_s = s;
        next_s.sync_out = 1'b0;
        next_s.cmp_evt = 1'b0;
        next_s.rdata = '0;
        // flag clears first so that events below win
        if (wr_stat) begin
            if (wdata_i[ST_PRI_BIT]) begin
                next_s.pri_flag = 1'b0;
            end
            if (wdata_i[ST_CMP_BIT]) begin
                next_s.cmp_flag = 1'b0;
            end
        end
        if (timer_on) begin
            if (s.cascade) begin
                // one 32-bit counter
                if (clr_any) begin
                    next_s.tmr_lo = '0; // [R12] [R14] [R16]
                    next_s.tmr_hi = '0;
                end else if (tick) begin
                    if (tmr_32 == per_32) begin
                        next_s.tmr_lo = '0; // [R2] [R19]
                        next_s.tmr_hi = '0;
                        next_s.sync_out = 1'b1;
                        next_s.pri_flag = 1'b1;
                        next_s.cmp_evt = 1'b1;
                        next_s.cmp_flag = 1'b1;
                    end else begin
                        next_s.tmr_lo = s.tmr_lo + 16'h0001;
                        if (s.tmr_lo == 16'hffff) begin
                            next_s.tmr_hi = s.tmr_hi + 16'h0001; // [R8]
                        end
                    end
                end
            end else begin
                // primary: only one that sees sync and trigger
                if (clr_any) begin
                    next_s.tmr_lo = '0; // [R5] [R12] [R14] [R16]
                end else if (tick) begin
                    if (s.tmr_lo == s.per_lo) begin
                        next_s.tmr_lo = '0; // [R3] [R19]
                        next_s.sync_out = 1'b1; // [R5]
                        next_s.pri_flag = 1'b1;
                    end else begin
                        next_s.tmr_lo = s.tmr_lo + 16'h0001; // [R15]
                    end
                end
                // secondary: free running periodic source
                if (tick) begin
                    if (s.tmr_hi == s.per_hi) begin
                        next_s.tmr_hi = '0; // [R4] [R19]
                        next_s.cmp_evt = 1'b1; // [R6] [R7]
                        next_s.cmp_flag = 1'b1; // [R7]
                    end else begin
                        next_s.tmr_hi = s.tmr_hi + 16'h0001;
                    end
                end
            end
        end
        // register writes
        if (wr_i) begin
            unique case (addr_i)
                OFF_CTRL_LO: begin
                    next_s.mode = wdata_i[CL_MODE_LSB +: 4];
                    next_s.capture_compare_select = wdata_i[CL_CAPTURE_COMPARE_SELECT_BIT];
                    next_s.cascade = wdata_i[CL_CASCADE_BIT]; // [R2]
                    next_s.clock_source_select = wdata_i[CL_CLOCK_SOURCE_SELECT_LSB +: 3]; // [R10]
                end
                OFF_CTRL_HI: begin
                    next_s.sync_sel = wdata_i[CH_SYNC_LSB +: 5];
                    next_s.trig_en = wdata_i[CH_TRIGGER_ENABLE_BIT]; // [R13]
                end
                OFF_TMR_LO: next_s.tmr_lo = wdata_i;
                OFF_TMR_HI: next_s.tmr_hi = wdata_i;
                OFF_PER_LO: next_s.per_lo = wdata_i;
                OFF_PER_HI: next_s.per_hi = wdata_i;
                default: begin
                end
            endcase
        end
        // reads: unmapped offsets answer zero
        if (rd_i) begin
            unique case (addr_i)
                OFF_CTRL_LO: begin
                    next_s.rdata[CL_MODE_LSB +: 4] = s.mode;
                    next_s.rdata[CL_CAPTURE_COMPARE_SELECT_BIT] = s.capture_compare_select;
                    next_s.rdata[CL_CASCADE_BIT] = s.cascade;
                    next_s.rdata[CL_CLOCK_SOURCE_SELECT_LSB +: 3] = s.clock_source_select;
                end
                OFF_CTRL_HI: begin
                    next_s.rdata[CH_SYNC_LSB +: 5] = s.sync_sel;
                    next_s.rdata[CH_TRIGGER_ENABLE_BIT] = s.trig_en;
                end
                OFF_STAT: begin
                    next_s.rdata[ST_PRI_BIT] = s.pri_flag;
                    next_s.rdata[ST_CMP_BIT] = s.cmp_flag;
                    next_s.rdata[ST_TRIG_BIT] = tif.trig_status; // [R15]
                end
                OFF_TMR_LO: next_s.rdata = s.tmr_lo;
                OFF_TMR_HI: next_s.rdata = s.tmr_hi;
                OFF_PER_LO: next_s.rdata = s.per_lo;
                OFF_PER_HI: next_s.rdata = s.per_hi;
                default: next_s.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.mode <= RST_CTRL[CL_MODE_LSB +: 4];
            s.clock_source_select <= RST_CTRL[CL_CLOCK_SOURCE_SELECT_LSB +: 3];
            s.tmr_lo <= RST_TMR;
            s.tmr_hi <= RST_TMR;
            s.per_lo <= RST_PER;
            s.per_hi <= RST_PER;
        end else begin
            s <= next_s;
        end
    end

    assign rdata_o = s.rdata;
    assign sync_out_o = s.sync_out;
    assign compare_event_o = s.cmp_evt;
    assign trig_status_o = tif.trig_status;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    chk_timer_gate: assert property ( // [R1]
        (!timer_on && !wr_i) |=> (s.tmr_lo == $past(s.tmr_lo))
        && (s.tmr_hi == $past(s.tmr_hi)))
        else $error("counter moved while timer mode off");

    chk_primary_wrap: assert property ( // [R3]
        (timer_on && !s.cascade && tick && !clr_any && !wr_tmr
         && (s.tmr_lo == s.per_lo))
        |=> (s.tmr_lo == 16'h0000) && sync_out_o)
        else $error("primary period match not handled");

    chk_secondary_cmp: assert property ( // [R7]
        (timer_on && !s.cascade && tick && !wr_tmr
         && (s.tmr_hi == s.per_hi))
        |=> (s.tmr_hi == 16'h0000) && compare_event_o)
        else $error("secondary period match not handled");

    chk_cascade_carry: assert property ( // [R8]
        (timer_on && s.cascade && tick && !clr_any && !wr_tmr
         && (s.tmr_lo == 16'hffff) && (tmr_32 != per_32))
        |=> (s.tmr_hi == $past(s.tmr_hi) + 16'h0001)
        && (s.tmr_lo == 16'h0000))
        else $error("low overflow did not carry");

    chk_sync_clear: assert property ( // [R12]
        (timer_on && tif.sync_clr && !wr_tmr) |=> (s.tmr_lo == 16'h0000))
        else $error("sync input did not clear counter");

    chk_trig_hold: assert property ( // [R14]
        (timer_on && tif.hold && !wr_tmr) [*2] |=> (s.tmr_lo == 16'h0000))
        else $error("counter ran without trigger");

    chk_trig_clear: assert property ( // [R16]
        (timer_on && tif.trig_clear) |=> (s.tmr_lo == 16'h0000))
        else $error("trigger clear did not reset counter");

    chk_trig_run: assert property ( // [R15]
        (timer_on && !s.cascade && s.trig_en && tif.trig_status && tick
         && !clr_any && !wr_tmr && (s.tmr_lo != s.per_lo))
        |=> (s.tmr_lo == $past(s.tmr_lo) + 16'h0001))
        else $error("triggered counter did not advance");

    chk_rdata_slot: assert property ( // own choice: strobed register access
        !rd_i |=> (rdata_o == 16'h0000))
        else $error("read data outside its slot");

    chk_sync_source: assert property ( // [R5] [R6]
        (!timer_on || !tick || clr_any || (s.tmr_lo != s.per_lo))
        |=> !sync_out_o)
        else $error("sync out without primary match");

    chk_cmp_source: assert property ( // [R7]
        (!timer_on || !tick || (s.cascade ? (tmr_32 != per_32)
         : (s.tmr_hi != s.per_hi))) |=> !compare_event_o)
        else $error("compare event without period match");

    chk_cmp_flag: assert property ( // [R7]
        compare_event_o |-> s.cmp_flag)
        else $error("compare event flag not set");

    chk_pri_flag: assert property ( // [R19]
        sync_out_o |-> s.pri_flag)
        else $error("primary period flag not set");

    chk_tick_gate: assert property ( // [R10]
        (timer_on && !tick && !clr_any && !wr_tmr)
        |=> (s.tmr_lo == $past(s.tmr_lo))
        && (s.tmr_hi == $past(s.tmr_hi)))
        else $error("counter moved without a tick");

    chk_alt_edge: assert property ( // [R10]
        ((s.clock_source_select != CLOCK_SOURCE_SELECT_SYS) && tick && !wr_i) |=> !tick)
        else $error("alternate source ticked twice in a row");

    chk_primary_run: assert property ( // [R3]
        (timer_on && !s.cascade && tick && !clr_any && !wr_tmr
         && (s.tmr_lo != s.per_lo))
        |=> (s.tmr_lo == $past(s.tmr_lo) + 16'h0001))
        else $error("primary counter did not advance");

    chk_secondary_run: assert property ( // [R4] [R5]
        (timer_on && !s.cascade && tick && !wr_tmr
         && (s.tmr_hi != s.per_hi))
        |=> (s.tmr_hi == $past(s.tmr_hi) + 16'h0001))
        else $error("secondary counter did not advance");

    chk_cascade_clear: assert property ( // [R2]
        (timer_on && s.cascade && clr_any && !wr_tmr)
        |=> (tmr_32 == 32'h00000000))
        else $error("32-bit counter not cleared");

    chk_trig_set: assert property ( // [R14]
        (s.trig_en && sync_src_i[s.sync_sel]) |=> trig_status_o)
        else $error("trigger input did not set status");

    chk_trig_drop: assert property ( // [R16]
        (tif.trig_clear && !sync_src_i[s.sync_sel]) |=> !trig_status_o)
        else $error("trigger clear left status set");

    chk_sync_mode: assert property ( // [R13]
        !s.trig_en |=> !trig_status_o)
        else $error("trigger status set in sync operation");

    cov_primary_wrap: cover property (sync_out_o && !s.cascade);
    cov_compare: cover property (compare_event_o && !s.cascade);
    cov_sync_clear: cover property (timer_on && tif.sync_clr);
    cov_trig_start: cover property (s.trig_en && tif.hold ##1 !tif.hold);
    cov_carry: cover property (s.cascade && timer_on
        && (s.tmr_lo == 16'hffff) ##1 (s.tmr_lo == 16'h0000));
endmodule : gpt_timebase

//--- gpt_src_model.sv
`timescale 1ns/100ps
// ****************************************************************
// on-chip clock and sync source partner
// ****************************************************************
module gpt_src_model (
    input wire logic sys_clk_i, // system clock
    input wire logic rst_i, // sync reset
    input wire logic [4:0] pulse_sel_i, // sync line to pulse
    input wire logic pulse_go_i, // pulse request
    output logic [31:0] sync_src_o, // sync / trigger lines
    output logic [7:1] clk_src_o // alternate clock sources
);
    logic [1:0] div;

    // free-running sources, one period every eight system cycles
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            div <= 2'h0;
            clk_src_o <= 7'h00;
        end else begin
            div <= div + 2'h1;
            if (div == 2'h3) begin
                clk_src_o <= ~clk_src_o;
            end
        end
    end

    // one-cycle pulse on the chosen line, all lines idle low
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !pulse_go_i) begin
            sync_src_o <= 32'h0;
        end else begin
            sync_src_o <= 32'h1 << pulse_sel_i;
        end
    end
endmodule : gpt_src_model

//--- gpt_timebase_tb.sv
`timescale 1ns/100ps
// ****************************************************************
// timebase testbench
// ****************************************************************
module gpt_timebase_tb;
    import gpt_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [4:0] pulse_sel = 5'h0;
    logic pulse_go = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic [7:1] clk_src_i;
    logic [31:0] sync_src_i;
    logic sync_out_o, compare_event_o, trig_status_o;
    int error_cnt = 0;
    int checks_done = 0;

    gpt_timebase i_gpt_timebase (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .clk_src_i(clk_src_i), .sync_src_i(sync_src_i),
        .sync_out_o(sync_out_o), .compare_event_o(compare_event_o),
        .trig_status_o(trig_status_o));
    gpt_src_model i_gpt_src_model (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pulse_sel_i(pulse_sel),
        .pulse_go_i(pulse_go), .sync_src_o(sync_src_i),
        .clk_src_o(clk_src_i));

    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // ****************************************************************
    // bus, stimulus and compare tasks
    // ****************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : cyc

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : reg_rd

    task automatic chk16(input string n, input logic [15:0] e,
                         input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk16

    task automatic chk1(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %b, seen %b", n, e, g);
        end
    endtask : chk1

    task automatic rdchk(input logic [3:0] a, input logic [15:0] e,
                         input string n);
        logic [15:0] v;
        reg_rd(a, v);
        chk16(n, e, v);
    endtask : rdchk

    task automatic pulse(input logic [4:0] k);
        @(posedge sys_clk_i);
        pulse_sel <= k;
        pulse_go <= 1'b1;
        @(posedge sys_clk_i);
        pulse_go <= 1'b0;
    endtask : pulse

    // cycles between two successive pulses of one event output
    task automatic gap(input bit cmp, output logic [15:0] n);
        int i;
        for (int p = 0; p < 2; p++) begin
            i = 0;
            do begin
                @(posedge sys_clk_i);
                #1;
                i++;
            end while ((cmp ? compare_event_o : sync_out_o) !== 1'b1
                       && i < 2000);
        end
        n = 16'(i);
    endtask : gap

    task automatic report_and_stop;
        $display("checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #500000;
        error_cnt++;
        report_and_stop();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        logic [15:0] v;
        logic [15:0] w;
        logic [15:0] nc;
        cyc(4);
        rst_i <= 1'b0;
        rdchk(OFF_CTRL_LO, RST_CTRL, "ctrl_lo reset");
        rdchk(OFF_CTRL_HI, RST_CTRL, "ctrl_hi reset");
        rdchk(OFF_STAT, 16'h0000, "stat reset");
        rdchk(OFF_PER_LO, RST_PER, "per_lo reset");
        rdchk(OFF_PER_HI, RST_PER, "per_hi reset");
        reg_wr(4'hf, 16'h1234);
        rdchk(4'hf, 16'h0000, "unmapped");
        // counting only in timer mode
        reg_wr(OFF_CTRL_LO, 16'h0001);
        reg_wr(OFF_TMR_LO, 16'h0005);
        cyc(10);
        rdchk(OFF_TMR_LO, 16'h0005, "tmr mode 1");
        reg_wr(OFF_CTRL_LO, 16'h0010);
        reg_wr(OFF_TMR_LO, 16'h0007);
        cyc(10);
        rdchk(OFF_TMR_LO, 16'h0007, "tmr capture_compare_select 1");
        reg_wr(OFF_CTRL_LO, 16'h0000);
        cyc(10);
        reg_rd(OFF_TMR_LO, v);
        chk1("tmr runs", 1'b1, v > 16'h0009);
        // split counters with their own periods
        reg_wr(OFF_PER_LO, 16'h0002);
        reg_wr(OFF_PER_HI, 16'h0004);
        reg_wr(OFF_TMR_LO, 16'h0000);
        reg_wr(OFF_TMR_HI, 16'h0000);
        gap(1'b0, v);
        chk16("primary gap", 16'd3, v);
        gap(1'b1, v);
        chk16("secondary gap", 16'd5, v);
        reg_wr(OFF_PER_LO, 16'hffff);
        reg_wr(OFF_TMR_LO, 16'h0000);
        v = 16'h0;
        nc = 16'h0;
        repeat (200) begin
            @(posedge sys_clk_i);
            #1;
            v += 16'(sync_out_o);
            nc += 16'(compare_event_o);
        end
        chk16("sync out count", 16'd0, v);
        chk16("compare count", 16'd40, nc);
        // every clock source code
        reg_wr(OFF_PER_LO, 16'h0003);
        for (int k = 0; k < 8; k++) begin
            reg_wr(OFF_CTRL_LO, 16'(k) << CL_CLOCK_SOURCE_SELECT_LSB);
            reg_wr(OFF_TMR_LO, 16'h0000);
            gap(1'b0, v);
            chk16("clock_source_select gap", (k == 0) ? 16'd4 : 16'd32, v);
        end
        // cascaded counter, loaded while stopped
        reg_wr(OFF_CTRL_LO, 16'h0021);
        reg_wr(OFF_PER_LO, 16'hffff);
        reg_wr(OFF_PER_HI, 16'hffff);
        reg_wr(OFF_TMR_HI, 16'h0000);
        reg_wr(OFF_TMR_LO, 16'hfffd);
        reg_wr(OFF_CTRL_LO, 16'h0020);
        cyc(10);
        rdchk(OFF_TMR_HI, 16'h0001, "carry into high");
        reg_wr(OFF_CTRL_LO, 16'h0021);
        reg_wr(OFF_PER_HI, 16'h0000);
        reg_wr(OFF_PER_LO, 16'h0005);
        reg_wr(OFF_TMR_HI, 16'h0000);
        reg_wr(OFF_TMR_LO, 16'h0000);
        reg_wr(OFF_CTRL_LO, 16'h0020);
        gap(1'b1, v);
        chk16("32-bit compare gap", 16'd6, v);
        gap(1'b0, v);
        chk16("32-bit sync gap", 16'd6, v);
        // sync operation, each source code except 11111
        reg_wr(OFF_CTRL_LO, 16'h0000);
        reg_wr(OFF_PER_LO, 16'hffff);
        reg_wr(OFF_PER_HI, 16'hffff);
        for (int k = 0; k < 31; k++) begin
            reg_wr(OFF_CTRL_HI, 16'(k));
            reg_wr(OFF_TMR_LO, 16'h0000);
            cyc(20);
            pulse(5'(k ^ 1));
            cyc(4);
            reg_rd(OFF_TMR_LO, v);
            chk1("other line ignored", 1'b1, v > 16'd19);
            pulse(5'(k));
            cyc(4);
            reg_rd(OFF_TMR_LO, v);
            chk1("sync clears", 1'b1, v < 16'd10);
        end
        // trigger operation
        reg_wr(OFF_CTRL_LO, 16'h0000);
        reg_wr(OFF_CTRL_HI, 16'h0083);
        cyc(10);
        rdchk(OFF_TMR_LO, 16'h0000, "held before trigger");
        chk1("status before trigger", 1'b0, trig_status_o);
        pulse(5'd3);
        cyc(10);
        #1;
        chk1("status after trigger", 1'b1, trig_status_o);
        rdchk(OFF_STAT, 16'h0083, "stat flags");
        reg_rd(OFF_TMR_LO, v);
        cyc(20);
        reg_rd(OFF_TMR_LO, w);
        chk16("trigger run", 16'd22, w - v);
        reg_wr(OFF_STAT, 16'h0023);
        cyc(3);
        #1;
        chk1("status cleared", 1'b0, trig_status_o);
        rdchk(OFF_STAT, 16'h0000, "stat cleared");
        rdchk(OFF_TMR_LO, 16'h0000, "zero after clear");
        cyc(20);
        rdchk(OFF_TMR_LO, 16'h0000, "held after clear");
        report_and_stop();
    end
endmodule : gpt_timebase_tb
